// File: rtl/adic_map.svh
// task-file field positions, command codes and limits for the command layer
// assumes inclusion by bare name from the command layer files
`ifndef ADIC_MAP_SVH
`define ADIC_MAP_SVH
`define ADIC_DH_DRV_BIT     4
`define ADIC_DH_LBA_BIT     6
`define ADIC_FIS_MAX_DW     12'h800
`define ADIC_CMD_NOP        8'h00
`define ADIC_CMD_RD_DMA     8'hc8
`define ADIC_CMD_WR_DMA     8'hca
`define ADIC_CMD_RD_SEC     8'h20
`define ADIC_CMD_WR_SEC     8'h30
`define ADIC_CMD_VFY0       8'h40
`define ADIC_CMD_VFY1       8'h41
`define ADIC_CMD_WR_NOE     8'h38
`define ADIC_CMD_WRM_NOE    8'hcd
`define ADIC_CMD_SET_MAX    8'hf9
`define ADIC_CMD_SET_FEAT   8'hef
`define ADIC_CMD_FLUSH      8'he7
`define ADIC_CMD_IDENT      8'hec
`define ADIC_CMD_CHK_PWR0   8'he5
`define ADIC_CMD_CHK_PWR1   8'h98
`define ADIC_CMD_LEG0       8'h87
`define ADIC_CMD_LEG1       8'hc0
`define ADIC_PWR_STANDBY    8'h00
`define ADIC_PWR_IDLE       8'hff
`define ADIC_ST_OK          8'h50
`define ADIC_ST_ERR         8'h51
`define ADIC_ERR_ABRT       8'h04
`endif

// File: rtl/adic_pkg.sv
// types for the dma data-in command layer
// assumes adic_map.svh constants
package adic_pkg;
  typedef struct packed {
    logic [7:0]  features_register;
    logic [7:0]  sector_count_register;
    logic [7:0]  sector_number_register;
    logic [15:0] cylinder_registers;
    logic [7:0]  drive_head_register;
    logic [7:0]  command;
  } adic_taskfile_t;
  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  error;
    logic [7:0]  sector_count_register;
    logic        irq;
  } adic_regfis_t;
  typedef enum logic [1:0] {
    device_idle_state        = 2'b00,
    dma_in_wait_state        = 2'b01,
    dma_in_send_data_state   = 2'b10,
    dma_in_send_status_state = 2'b11
  } adic_state_t;
endpackage : adic_pkg

// File: rtl/adic_cmd_layer.sv
// device command layer: task-file decode and dma data-in sequencing
// assumes synchronous inputs; transport layer acks with one-cycle pulses
// How it works
// - only the read dma command (c8h) enters dma-in wait state from idle
// - in wait state, stage requested data for the next data fis
// - data staged, move to send-data state
// - all data done or error abort, move to send-status state
// - send-data asks transport to transmit a data fis
// - each data fis carries at most 2048 dwords
// - data fis finished, return to dma-in wait state
// - send-status asks for register fis with interrupt bit set
// - register fis sent, go to device idle
// - legacy codes complete as no-operation with good status
// - valid-marked registers are parameters used by the command
// - full drive/head decode gives drive bit and head bits
// - drive-only commands decode drive bit, head field ignored
// - command-specific registers interpreted per command
// - lba commands accept chs or lba addressing
// - write-without-erase decodes as write with full address/count
// - set-max takes count, number, cylinder, drive/head, lba form
// - set-features routes the features register as subcommand
// - check-power reports 00h standby or ffh idle in sector count
`timescale 1ns/100ps
`include "adic_map.svh"
`default_nettype none
module adic_cmd_layer
  import adic_pkg::*;
(
  // clock and reset
  input  wire logic           i_sys_clk,
  input  wire logic           i_arst_n,
  // command from task file
  input  wire logic           i_cmd_valid,
  input  wire adic_taskfile_t i_taskfile,
  input  wire logic           i_standby,
  // media side
  input  wire logic [15:0]    i_total_dw,
  input  wire logic           i_data_ready,
  input  wire logic           i_abort_err,
  // transport layer
  input  wire logic           i_data_fis_done,
  input  wire logic           i_reg_fis_done,
  output logic                o_data_fis_req,
  output logic [11:0]         o_data_fis_dw,
  output logic                o_stage_req,
  output logic                o_reg_fis_req,
  output adic_regfis_t        o_reg_fis,
  // decoded parameters
  output logic                o_busy,
  output logic                o_is_write,
  output logic                o_lba_mode,
  output logic [27:0]         o_address,
  output logic [7:0]          o_count,
  output logic                o_drive,
  output logic [3:0]          o_head,
  output logic                o_feat_valid,
  output logic [7:0]          o_feature
);

  ////////////////////////////////////////////////////////////////////////
  // command classes
  logic [7:0] cmd;
  logic       c_dma_rd;
  logic       c_addr;
  logic       c_wr;
  logic       c_drv_only;
  logic       c_nop;
  logic       c_chk;
  assign cmd = i_taskfile.command;
  always_comb
  begin
    c_dma_rd   = (cmd == `ADIC_CMD_RD_DMA);
    c_wr       = (cmd == `ADIC_CMD_WR_DMA) | (cmd == `ADIC_CMD_WR_SEC) |
                 (cmd == `ADIC_CMD_WR_NOE) | (cmd == `ADIC_CMD_WRM_NOE);
    c_addr     = c_dma_rd | c_wr | (cmd == `ADIC_CMD_RD_SEC) |
                 (cmd == `ADIC_CMD_VFY0) | (cmd == `ADIC_CMD_VFY1) |
                 (cmd == `ADIC_CMD_SET_MAX);
    c_chk      = (cmd == `ADIC_CMD_CHK_PWR0) | (cmd == `ADIC_CMD_CHK_PWR1);
    c_drv_only = (cmd == `ADIC_CMD_FLUSH) | (cmd == `ADIC_CMD_IDENT) |
                 (cmd == `ADIC_CMD_SET_FEAT) | c_chk;
    c_nop      = (cmd == `ADIC_CMD_NOP) | (cmd == `ADIC_CMD_LEG0) |
                 (cmd == `ADIC_CMD_LEG1);
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  adic_state_t  state_q, state_d;
  logic [15:0]  left_q, left_d;
  logic [11:0]  chunk_q, chunk_d;
  logic         dreq_q, dreq_d;
  logic         sreq_q, sreq_d;
  logic         rreq_q, rreq_d;
  adic_regfis_t rfis_q, rfis_d;
  logic         wr_q, wr_d;
  logic         lba_q, lba_d;
  logic [27:0]  addr_q, addr_d;
  logic [7:0]   cnt_q, cnt_d;
  logic         drv_q, drv_d;
  logic [3:0]   head_q, head_d;
  logic         fv_q, fv_d;
  logic [7:0]   feat_q, feat_d;
  logic         accept;
  assign accept = i_cmd_valid & (state_q == device_idle_state);

  always_comb
  begin
    state_d = state_q;
    left_d  = left_q;
    chunk_d = chunk_q;
    dreq_d  = 1'b0;
    sreq_d  = 1'b0;
    rreq_d  = rreq_q;
    rfis_d  = rfis_q;
    wr_d    = wr_q;
    lba_d   = lba_q;
    addr_d  = addr_q;
    cnt_d   = cnt_q;
    drv_d   = drv_q;
    head_d  = head_q;
    fv_d    = 1'b0;
    feat_d  = feat_q;
    case (state_q)
      device_idle_state:
      begin
        if (accept)
        begin
          drv_d = i_taskfile.drive_head_register[`ADIC_DH_DRV_BIT];
          rfis_d = '{status: `ADIC_ST_OK, error: 8'h00,
                     sector_count_register: i_taskfile.sector_count_register,
                     irq: 1'b1};
          if (c_addr)
          begin
            wr_d   = c_wr;
            lba_d  = i_taskfile.drive_head_register[`ADIC_DH_LBA_BIT];
            head_d = i_taskfile.drive_head_register[3:0];
            addr_d = {i_taskfile.drive_head_register[3:0],
                      i_taskfile.cylinder_registers,
                      i_taskfile.sector_number_register};
            cnt_d  = i_taskfile.sector_count_register;
          end
          else
          begin
            head_d = 4'h0;
          end
          if (cmd == `ADIC_CMD_SET_FEAT)
          begin
            fv_d   = 1'b1;
            feat_d = i_taskfile.features_register;
          end
          if (c_chk)
            rfis_d.sector_count_register = i_standby ? `ADIC_PWR_STANDBY
                                                     : `ADIC_PWR_IDLE;
          if (c_dma_rd)
          begin
            left_d  = i_total_dw;
            state_d = dma_in_wait_state;
            sreq_d  = 1'b1;
          end
          else
          begin
            if (!(c_addr | c_drv_only | c_nop))
              rfis_d = '{status: `ADIC_ST_ERR, error: `ADIC_ERR_ABRT,
                         sector_count_register:
                           i_taskfile.sector_count_register,
                         irq: 1'b1};
            rreq_d  = 1'b1;
            state_d = dma_in_send_status_state;
          end
        end
      end
      dma_in_wait_state:
      begin
        if (i_abort_err | (left_q == 16'h0000))
        begin
          if (i_abort_err)
          begin
            rfis_d.status = `ADIC_ST_ERR;
            rfis_d.error  = `ADIC_ERR_ABRT;
          end
          rreq_d  = 1'b1;
          state_d = dma_in_send_status_state;
        end
        else if (i_data_ready)
        begin
          chunk_d = (left_q > 16'(`ADIC_FIS_MAX_DW)) ? `ADIC_FIS_MAX_DW
                                                   : left_q[11:0];
          dreq_d  = 1'b1;
          state_d = dma_in_send_data_state;
        end
        else
          sreq_d = 1'b1;
      end
      dma_in_send_data_state:
      begin
        if (i_data_fis_done)
        begin
          left_d  = left_q - {4'h0, chunk_q};
          sreq_d  = 1'b1;
          state_d = dma_in_wait_state;
        end
      end
      dma_in_send_status_state:
      begin
        if (i_reg_fis_done)
        begin
          rreq_d  = 1'b0;
          state_d = device_idle_state;
        end
      end
      default:
        state_d = device_idle_state;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q <= device_idle_state;
      left_q  <= 16'h0000;
      chunk_q <= 12'h000;
      dreq_q  <= 1'b0;
      sreq_q  <= 1'b0;
      rreq_q  <= 1'b0;
      rfis_q  <= '0;
      wr_q    <= 1'b0;
      lba_q   <= 1'b0;
      addr_q  <= 28'h0000000;
      cnt_q   <= 8'h00;
      drv_q   <= 1'b0;
      head_q  <= 4'h0;
      fv_q    <= 1'b0;
      feat_q  <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      left_q  <= left_d;
      chunk_q <= chunk_d;
      dreq_q  <= dreq_d;
      sreq_q  <= sreq_d;
      rreq_q  <= rreq_d;
      rfis_q  <= rfis_d;
      wr_q    <= wr_d;
      lba_q   <= lba_d;
      addr_q  <= addr_d;
      cnt_q   <= cnt_d;
      drv_q   <= drv_d;
      head_q  <= head_d;
      fv_q    <= fv_d;
      feat_q  <= feat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  logic busy_q;
  logic busy_d;
  always_comb
  begin
    busy_d = (state_d != device_idle_state);
  end
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      busy_q <= 1'b0;
    else
      busy_q <= busy_d;
  end
  assign o_busy         = busy_q;
  assign o_data_fis_req = dreq_q;
  assign o_data_fis_dw  = chunk_q;
  assign o_stage_req    = sreq_q;
  assign o_reg_fis_req  = rreq_q;
  assign o_reg_fis      = rfis_q;
  assign o_is_write     = wr_q;
  assign o_lba_mode     = lba_q;
  assign o_address      = addr_q;
  assign o_count        = cnt_q;
  assign o_drive        = drv_q;
  assign o_head         = head_q;
  assign o_feat_valid   = fv_q;
  assign o_feature      = feat_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_data_req;
    dreq_q && state_q == dma_in_send_data_state;
  endsequence
  sequence s_back_wait;
    state_q == dma_in_wait_state;
  endsequence

  a_dma_entry: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept && c_dma_rd |=> state_q == dma_in_wait_state)
    else $error("dma read not entering wait state");
  a_stage_req: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == dma_in_wait_state && !i_data_ready && !i_abort_err &&
    left_q != 16'h0000 |=> sreq_q)
    else $error("no staging request while waiting");
  a_to_send: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == dma_in_wait_state && i_data_ready && !i_abort_err &&
    left_q != 16'h0000 |=> s_data_req)
    else $error("ready data not sent");
  a_to_status: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == dma_in_wait_state && (i_abort_err || left_q == 16'h0000)
    |=> state_q == dma_in_send_status_state && rreq_q)
    else $error("done or abort not reaching status");
  a_fis_size: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    dreq_q |-> chunk_q <= `ADIC_FIS_MAX_DW && chunk_q != 12'h000)
    else $error("data fis size out of range");
  a_fis_return: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == dma_in_send_data_state && i_data_fis_done
    |=> s_back_wait ##0 left_q == $past(left_q) - {4'h0, $past(chunk_q)})
    else $error("bad return after data fis");
  a_status_irq: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    rreq_q |-> rfis_q.irq)
    else $error("status fis without interrupt bit");
  a_idle_after: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == dma_in_send_status_state && i_reg_fis_done
    |=> state_q == device_idle_state && !rreq_q)
    else $error("not idle after status fis");
  a_nop_good: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept && c_nop |=> rfis_q.status == `ADIC_ST_OK)
    else $error("legacy code not completed clean");
  a_abort_bad: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept && !(c_addr | c_drv_only | c_nop)
    |=> rfis_q.error == `ADIC_ERR_ABRT && rreq_q)
    else $error("unsupported code not aborted");
  a_power_rpt: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept && c_chk |=> rfis_q.sector_count_register ==
      ($past(i_standby) ? `ADIC_PWR_STANDBY : `ADIC_PWR_IDLE))
    else $error("wrong power report");
  a_feat_route: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept && cmd == `ADIC_CMD_SET_FEAT
    |=> fv_q && feat_q == $past(i_taskfile.features_register))
    else $error("feature not routed");
  a_head_drop: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept && c_drv_only |=> head_q == 4'h0)
    else $error("head used on drive-only command");
  a_drive_take: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept |=> drv_q ==
      $past(i_taskfile.drive_head_register[`ADIC_DH_DRV_BIT]))
    else $error("drive bit not captured");
  a_addr_take: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept && c_addr |=> cnt_q == $past(i_taskfile.sector_count_register)
      && addr_q[23:0] == $past({i_taskfile.cylinder_registers,
                                i_taskfile.sector_number_register})
      && addr_q[27:24] == $past(i_taskfile.drive_head_register[3:0]))
    else $error("address parameters not captured");
  a_lba_take: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept && c_addr |=> lba_q ==
      $past(i_taskfile.drive_head_register[`ADIC_DH_LBA_BIT]))
    else $error("addressing mode not captured");
  a_wr_noerase: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept && (cmd == `ADIC_CMD_WR_NOE || cmd == `ADIC_CMD_WRM_NOE)
    |=> wr_q && cnt_q == $past(i_taskfile.sector_count_register))
    else $error("write without erase not decoded as write");
  a_busy_rise: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    accept |=> busy_q)
    else $error("busy not raised on accepted command");

endmodule : adic_cmd_layer
`default_nettype wire

// File: dv/adic_xport_model.sv
// transport layer and media stand-in facing the command layer
// assumes registered requests; answers quickly or, with i_slow, late
`timescale 1ns/100ps
`default_nettype none
module adic_xport_model
(
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  // pacing
  input  wire logic i_slow,
  // requests
  input  wire logic i_stage_req,
  input  wire logic i_data_fis_req,
  input  wire logic i_reg_fis_req,
  // answers
  output logic      o_data_ready,
  output logic      o_data_fis_done,
  output logic      o_reg_fis_done
);
  int   stage_cnt;
  int   data_cnt;
  int   reg_cnt;
  logic reg_sent;
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_data_ready    <= 1'b0;
      o_data_fis_done <= 1'b0;
      o_reg_fis_done  <= 1'b0;
      stage_cnt       <= 0;
      data_cnt        <= 0;
      reg_cnt         <= 0;
      reg_sent        <= 1'b0;
    end
    else
    begin
      o_data_fis_done <= (data_cnt == 1);
      o_reg_fis_done  <= 1'b0;
      if (data_cnt > 0)
        data_cnt <= data_cnt - 1;
      // staged data is used up by each data fis
      if (i_data_fis_req)
      begin
        o_data_ready <= 1'b0;
        stage_cnt    <= 0;
        data_cnt     <= i_slow ? 6 : 1;
      end
      else if (i_stage_req && !o_data_ready)
      begin
        stage_cnt    <= stage_cnt + 1;
        o_data_ready <= stage_cnt >= (i_slow ? 4 : 0);
      end
      // one done pulse per status request
      if (!i_reg_fis_req)
      begin
        reg_sent <= 1'b0;
        reg_cnt  <= 0;
      end
      else if (!reg_sent)
      begin
        reg_cnt <= reg_cnt + 1;
        if (reg_cnt >= (i_slow ? 3 : 0))
        begin
          o_reg_fis_done <= 1'b1;
          reg_sent       <= 1'b1;
        end
      end
    end
  end
endmodule : adic_xport_model
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the dma data-in command layer
// assumes adic_xport_model answers on the transport side
`timescale 1ns/100ps
`include "adic_map.svh"
`default_nettype none
module tb_top
  import adic_pkg::*;
;
  logic           i_sys_clk, i_arst_n, i_cmd_valid, i_standby, i_abort_err;
  logic           i_slow, rdy, fis_done, reg_done;
  adic_taskfile_t i_taskfile;
  logic [15:0]    i_total_dw, left;
  logic           o_data_fis_req, o_stage_req, o_reg_fis_req, o_busy;
  logic           o_is_write, o_lba_mode, o_drive, o_feat_valid, feat_seen;
  logic [11:0]    o_data_fis_dw;
  logic [27:0]    o_address;
  logic [7:0]     o_count, o_feature;
  logic [3:0]     o_head;
  adic_regfis_t   o_reg_fis, fis_q;
  int             n_fail, compares, seed, nfis;
  logic [7:0]     cmd_tab [19] = '{8'h00, 8'hc8, 8'hca, 8'h20, 8'h30, 8'h40,
    8'h41, 8'h38, 8'hcd, 8'hf9, 8'hef, 8'he7, 8'hec, 8'he5, 8'h98, 8'h87,
    8'hc0, 8'h5a, 8'hff};
  logic [15:0]    tot_tab [7] = '{16'h0, 16'h1, 16'h7ff, 16'h800, 16'h801,
    16'h1000, 16'hbb8};

  adic_cmd_layer dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_cmd_valid(i_cmd_valid), .i_taskfile(i_taskfile),
    .i_standby(i_standby), .i_total_dw(i_total_dw), .i_data_ready(rdy),
    .i_abort_err(i_abort_err), .i_data_fis_done(fis_done),
    .i_reg_fis_done(reg_done), .o_data_fis_req(o_data_fis_req),
    .o_data_fis_dw(o_data_fis_dw), .o_stage_req(o_stage_req),
    .o_reg_fis_req(o_reg_fis_req), .o_reg_fis(o_reg_fis), .o_busy(o_busy),
    .o_is_write(o_is_write), .o_lba_mode(o_lba_mode),
    .o_address(o_address), .o_count(o_count), .o_drive(o_drive),
    .o_head(o_head), .o_feat_valid(o_feat_valid), .o_feature(o_feature));
  adic_xport_model xport (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_slow(i_slow), .i_stage_req(o_stage_req),
    .i_data_fis_req(o_data_fis_req), .i_reg_fis_req(o_reg_fis_req),
    .o_data_ready(rdy), .o_data_fis_done(fis_done),
    .o_reg_fis_done(reg_done));

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [27:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic logic known(input logic [7:0] c);
    known = (c != 8'h5a) && (c != 8'hff);
  endfunction : known

  function automatic logic is_addr(input logic [7:0] c);
    is_addr = c inside {8'hc8, 8'hca, 8'h20, 8'h30, 8'h40, 8'h41, 8'h38,
                        8'hcd, 8'hf9};
  endfunction : is_addr

  function automatic adic_taskfile_t mk(input logic [7:0] c);
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    mk = r[55:0];
    mk.command = c;
  endfunction : mk

  ////////////////////////////////////////////////////////////////////////
  // abort_at: data fis count at which the media error rises, -1 for never
  task automatic run(input adic_taskfile_t tf, input logic [15:0] tot,
                     input int abort_at);
    int          i;
    logic [7:0]  c, exp_st, exp_pw;
    logic [3:0]  hd;
    logic [11:0] exp_dw;
    logic [27:0] exp_adr;
    logic        nv, na, busy_seen, exp_wr;
    c = tf.command;
    hd = tf.drive_head_register[3:0];
    left = (c == `ADIC_CMD_RD_DMA) ? tot : 16'h0;
    nfis = 0;
    feat_seen = 1'b0;
    fis_q = '0;
    @(posedge i_sys_clk);
    i_taskfile <= tf;
    i_total_dw <= tot;
    i_abort_err <= (abort_at == 0);
    @(posedge i_sys_clk);
    i_cmd_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_cmd_valid <= 1'b0;
    busy_seen = 1'b1;
    for (i = 0; i < 40000 && busy_seen; i++)
    begin
      @(negedge i_sys_clk);
      busy_seen = o_busy;
      if (i == 0)
        chk("busy", 1'b1, o_busy);
      // a command while busy must be ignored
      nv = o_data_fis_req && nfis == 0;
      na = 1'b0;
      if (o_data_fis_req)
      begin
        exp_dw = (left >= 16'h800) ? 12'h800 : left[11:0];
        chk("fis_dw", exp_dw, o_data_fis_dw);
        left = left - {4'h0, exp_dw};
        nfis++;
        na = (nfis == abort_at);
      end
      if (o_reg_fis_req)
        fis_q = o_reg_fis;
      if (o_feat_valid)
        feat_seen = 1'b1;
      @(posedge i_sys_clk);
      i_cmd_valid <= nv;
      if (nv)
      begin
        i_taskfile.sector_count_register <= ~tf.sector_count_register;
        i_taskfile.command <= 8'h5a;
      end
      if (na)
        i_abort_err <= 1'b1;
    end
    chk("busy_end", 1'b0, busy_seen);
    if (busy_seen)
      end_of_test();
    i_abort_err <= 1'b0;
    if (abort_at < 0)
      chk("left", 16'h0, left);
    else
      chk("nfis", 28'(abort_at), 28'(nfis));
    chk("irq", 1'b1, fis_q.irq);
    exp_st = (known(c) && abort_at < 0) ? `ADIC_ST_OK : `ADIC_ST_ERR;
    chk("status", exp_st, fis_q.status);
    if (!known(c) || abort_at >= 0)
      chk("error", `ADIC_ERR_ABRT, fis_q.error);
    if (known(c))
      chk("drive", tf.drive_head_register[4], o_drive);
    if (is_addr(c))
    begin
      exp_adr = {hd, tf.cylinder_registers, tf.sector_number_register};
      chk("address", exp_adr, o_address);
      chk("lba", tf.drive_head_register[6], o_lba_mode);
      chk("count", tf.sector_count_register, o_count);
      chk("head", hd, o_head);
      exp_wr = c inside {8'hca, 8'h30, 8'h38, 8'hcd};
      if (c != `ADIC_CMD_SET_MAX)
        chk("write", exp_wr, o_is_write);
    end
    else if (known(c))
      chk("head", 4'h0, o_head);
    exp_pw = i_standby ? 8'h00 : 8'hff;
    if (c == `ADIC_CMD_CHK_PWR0 || c == `ADIC_CMD_CHK_PWR1)
      chk("power", exp_pw, fis_q.sector_count_register);
    chk("feat_valid", c == `ADIC_CMD_SET_FEAT, feat_seen);
    if (c == `ADIC_CMD_SET_FEAT)
      chk("feature", tf.features_register, o_feature);
  endtask : run

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_sys_clk = 1'b0;
    forever
      #12.5 i_sys_clk = ~i_sys_clk;
  end

  initial
  begin
    seed = 32'h86a84108;
    i_arst_n = 1'b0;
    i_cmd_valid = 1'b0;
    i_taskfile = '0;
    i_standby = 1'b0;
    i_abort_err = 1'b0;
    i_total_dw = 16'h0;
    i_slow = 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    foreach (tot_tab[k])
      run(mk(`ADIC_CMD_RD_DMA), tot_tab[k], -1);
    run(mk(`ADIC_CMD_RD_DMA), 16'h1800, 0);
    run(mk(`ADIC_CMD_RD_DMA), 16'h1800, 1);
    foreach (cmd_tab[k])
    begin
      i_standby <= k[0];
      run(mk(cmd_tab[k]), 16'h10, -1);
    end
    repeat (60)
    begin
      i_slow <= 1'($random(seed));
      i_standby <= 1'($random(seed));
      run(mk(cmd_tab[$unsigned($random(seed)) % 19]),
          16'($random(seed) & 32'h1fff), -1);
    end
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
